// ---- design/dau_defines.svh ----
/*
 * constants of the signal processor arithmetic unit: widths, part positions,
 * pre-shifter distances and reset values.
 * assumes inclusion by bare name from the package and the design file.
 */
`ifndef DAU_DEFINES_SVH
`define DAU_DEFINES_SVH

`define DAU_WORD_W      16
`define DAU_ACC_W       40
`define DAU_NUM_REGS    8
`define DAU_IDX_W       3
`define DAU_SHAMT_W     6
`define DAU_LOW_LSB     0
`define DAU_LOW_MSB     15
`define DAU_HIGH_LSB    16
`define DAU_HIGH_MSB    31
`define DAU_EXT_LSB     32
`define DAU_EXT_MSB     39
`define DAU_PRE_SHIFT_1  6'h01
`define DAU_PRE_SHIFT_16 6'h10
`define DAU_REG_RESET   40'h00_0000_0000
`define DAU_SHAMT_MAX   6'h27

`endif

// ---- design/dau_pkg.sv ----
/*
 * types of the arithmetic unit: operation codes, part masks and the
 * request and answer structs that travel between the unit and program control.
 * assumes dau_defines.svh is on the include path.
 */
`include "dau_defines.svh"

package dau_pkg;

	// which unit a request runs on and what it does
	typedef enum logic [3:0] {
		DAU_OP_NOP,
		DAU_OP_MAC_ADD,
		DAU_OP_MAC_SUB,
		DAU_OP_ALU_ADD,
		DAU_OP_ALU_SUB,
		DAU_OP_ALU_AND,
		DAU_OP_ALU_OR,
		DAU_OP_ALU_XOR,
		DAU_OP_ALU_NEG,
		DAU_OP_ALU_NOT,
		DAU_OP_ALU_MOV,
		DAU_OP_SHL,
		DAU_OP_SHR_ARITH,
		DAU_OP_SHR_LOGIC,
		DAU_OP_LOAD
	} dau_op_e;

	// pre-shifter selection on the accumulate operand
	typedef enum logic [1:0] {
		DAU_PRE_NONE,
		DAU_PRE_R1,
		DAU_PRE_R16
	} dau_pre_e;

	// parts of a general register written: bit0 low, bit1 high, bit2 extension
	typedef logic [2:0] dau_part_t;

	typedef struct packed {
		logic                         valid;
		dau_op_e                      op;
		dau_pre_e                     pre;
		logic [`DAU_IDX_W-1:0]        src_a;
		logic [`DAU_IDX_W-1:0]        src_b;
		logic [`DAU_IDX_W-1:0]        dst;
		dau_part_t                    dst_parts;
		logic                         mul_a_high;
		logic                         mul_b_high;
		logic [`DAU_SHAMT_W-1:0]      shamt;
		logic [`DAU_ACC_W-1:0]        load_data;
	} dau_req_s;

	typedef struct packed {
		logic                         valid;
		logic [`DAU_IDX_W-1:0]        dst;
		logic [`DAU_ACC_W-1:0]        result;
	} dau_rsp_s;

	typedef struct packed {
		logic [`DAU_IDX_W-1:0]        idx;
	} dau_rd_s;

endpackage

// ---- design/dau_unit.sv ----
/*
 * arithmetic unit: eight 40-bit general registers with part-wise writes,
 * multiply-accumulator with arithmetic pre-shifter, 40-bit alu and barrel
 * shifter. one request is taken per clock and retired on the next edge.
 * operands are read from the registered file, so a request sees the write of
 * the request just before it without any forwarding path or stall.
 * arithmetic wraps at 40 bits; there is no saturation and no status flag.
 * shift counts past 39 are clamped: left and logical give zero, arithmetic
 * gives all copies of the sign.
 * assumes program control issues decoded requests and data memory reads the
 * store port; all in the single system clock domain.
 * assumes the request is stable around each rising edge; it is not synchronised,
 * since it comes from logic on the same clock.
 */
`timescale 1ns/1ps
`include "dau_defines.svh"

module dau_unit (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               arst_n_i,
	// decoded operation from program control
	input  wire dau_pkg::dau_req_s  req_i,
	// store read port toward data memory
	input  wire dau_pkg::dau_rd_s   store_rd_i,
	output logic [`DAU_ACC_W-1:0]   store_data_o,
	// retired result
	output dau_pkg::dau_rsp_s       rsp_o
);
	import dau_pkg::*;

	// whole state of the unit in one record: the file, the retired answer and the
	// store word are registered together, so every output comes straight from a flop
	typedef struct packed {
		logic [`DAU_NUM_REGS-1:0][`DAU_ACC_W-1:0] general_regs;
		dau_rsp_s                                 rsp;
		logic [`DAU_ACC_W-1:0]                    store_data;
	} dau_state_s;

	dau_state_s state;
	dau_state_s next_state;

	// sign extension of the 32-bit product to the accumulator width
	function automatic logic [`DAU_ACC_W-1:0] sext_product(input logic [2*`DAU_WORD_W-1:0] p);
		sext_product = {{(`DAU_ACC_W-2*`DAU_WORD_W){p[2*`DAU_WORD_W-1]}}, p};
	endfunction

	// mac: the sign-extended product is added to or taken from the accumulate operand
	// both directions share this one function, so the extension is written once
	function automatic logic [`DAU_ACC_W-1:0] mac40(input logic [`DAU_ACC_W-1:0] acc,
		input logic signed [2*`DAU_WORD_W-1:0] p, input logic sub);
		if (sub) begin
			mac40 = acc - sext_product(p);
		end else begin
			mac40 = acc + sext_product(p);
		end
	endfunction

	// arithmetic right shift, sign fills from the top
	// the signed shift stands in a statement of its own: inside a conditional with an
	// unsigned arm it would lose its sign and shift in zeros
	function automatic logic [`DAU_ACC_W-1:0] sra40(input logic [`DAU_ACC_W-1:0] v,
		input logic [`DAU_SHAMT_W-1:0] n);
		logic signed [`DAU_ACC_W-1:0] s;
		s = v;
		if (n > `DAU_SHAMT_MAX) begin
			sra40 = {`DAU_ACC_W{v[`DAU_ACC_W-1]}};
		end else begin
			s = s >>> n;
			sra40 = s;
		end
	endfunction

	// left shift, zeros enter at the bottom; counts past 39 leave all zeros
	function automatic logic [`DAU_ACC_W-1:0] sll40(input logic [`DAU_ACC_W-1:0] v,
		input logic [`DAU_SHAMT_W-1:0] n);
		if (n > `DAU_SHAMT_MAX) begin
			sll40 = '0;
		end else begin
			sll40 = v << n;
		end
	endfunction

	// logical right shift, zeros enter from the top; counts past 39 leave all zeros
	function automatic logic [`DAU_ACC_W-1:0] srl40(input logic [`DAU_ACC_W-1:0] v,
		input logic [`DAU_SHAMT_W-1:0] n);
		if (n > `DAU_SHAMT_MAX) begin
			srl40 = '0;
		end else begin
			srl40 = v >> n;
		end
	endfunction

	// pre-shift of the accumulate operand; code 3 is unused and passes the value through
	// so a stray code never corrupts an accumulation
	function automatic logic [`DAU_ACC_W-1:0] mac_pre_shifter(input logic [`DAU_ACC_W-1:0] v, input dau_pre_e sel);
		unique case (sel)
			DAU_PRE_R1: mac_pre_shifter = sra40(v, `DAU_PRE_SHIFT_1);
			DAU_PRE_R16: mac_pre_shifter = sra40(v, `DAU_PRE_SHIFT_16);
			default: mac_pre_shifter = v;
		endcase
	endfunction

	// alu: one or two 40-bit operands, wrap-around arithmetic
	// codes that are not alu operations pass the first operand through
	function automatic logic [`DAU_ACC_W-1:0] alu40(input dau_op_e op, input logic [`DAU_ACC_W-1:0] a,
		input logic [`DAU_ACC_W-1:0] b);
		unique case (op)
			DAU_OP_ALU_ADD: alu40 = a + b;
			DAU_OP_ALU_SUB: alu40 = a - b;
			DAU_OP_ALU_AND: alu40 = a & b;
			DAU_OP_ALU_OR:  alu40 = a | b;
			DAU_OP_ALU_XOR: alu40 = a ^ b;
			DAU_OP_ALU_NEG: alu40 = '0 - a;
			DAU_OP_ALU_NOT: alu40 = ~a;
			DAU_OP_ALU_MOV: alu40 = a;
			default: alu40 = a;
		endcase
	endfunction

	// part-wise merge: only selected parts of the destination change
	// a load of one part therefore leaves the other two as they were
	function automatic logic [`DAU_ACC_W-1:0] merge_parts(input logic [`DAU_ACC_W-1:0] old_v,
		input logic [`DAU_ACC_W-1:0] new_v, input dau_part_t parts);
		logic [`DAU_ACC_W-1:0] m;
		m = old_v;
		if (parts[0]) begin
			m[`DAU_LOW_MSB:`DAU_LOW_LSB] = new_v[`DAU_LOW_MSB:`DAU_LOW_LSB];
		end
		if (parts[1]) begin
			m[`DAU_HIGH_MSB:`DAU_HIGH_LSB] = new_v[`DAU_HIGH_MSB:`DAU_HIGH_LSB];
		end
		if (parts[2]) begin
			m[`DAU_EXT_MSB:`DAU_EXT_LSB] = new_v[`DAU_EXT_MSB:`DAU_EXT_LSB];
		end
		merge_parts = m;
	endfunction

	// per-request values, all recomputed every clock from the registered file
	logic [`DAU_ACC_W-1:0] op_a;
	logic [`DAU_ACC_W-1:0] op_b;
	logic [`DAU_ACC_W-1:0] acc_in;
	logic [`DAU_WORD_W-1:0] mul_x;
	logic [`DAU_WORD_W-1:0] mul_y;
	logic signed [2*`DAU_WORD_W-1:0] product;
	logic [`DAU_ACC_W-1:0] result;
	logic                  writes;

	// operand fetch, mac, alu and shifter: one result per clock
	// the whole datapath settles within one clock; that costs a long path from the
	// file through the multiplier and adder, traded for no stall and no bypass
	always_comb begin
		next_state = state;
		op_a = state.general_regs[req_i.src_a];
		op_b = state.general_regs[req_i.src_b];
		// multiplier takes the high or low part of each source
		// both are taken as signed 16-bit values
		mul_x = req_i.mul_a_high ? op_a[`DAU_HIGH_MSB:`DAU_HIGH_LSB] : op_a[`DAU_LOW_MSB:`DAU_LOW_LSB];
		mul_y = req_i.mul_b_high ? op_b[`DAU_HIGH_MSB:`DAU_HIGH_LSB] : op_b[`DAU_LOW_MSB:`DAU_LOW_LSB];
		product = $signed(mul_x) * $signed(mul_y);
		// the accumulate operand is the destination register itself
		acc_in = mac_pre_shifter(state.general_regs[req_i.dst], req_i.pre);
		writes = 1'b1;
		result = op_a;
		unique case (req_i.op)
			DAU_OP_MAC_ADD: result = mac40(acc_in, product, 1'b0);
			DAU_OP_MAC_SUB: result = mac40(acc_in, product, 1'b1);
			// alu codes share one function so the operation decode stays in one place
			DAU_OP_ALU_ADD: result = alu40(req_i.op, op_a, op_b);
			DAU_OP_ALU_SUB: result = alu40(req_i.op, op_a, op_b);
			DAU_OP_ALU_AND: result = alu40(req_i.op, op_a, op_b);
			DAU_OP_ALU_OR:  result = alu40(req_i.op, op_a, op_b);
			DAU_OP_ALU_XOR: result = alu40(req_i.op, op_a, op_b);
			DAU_OP_ALU_NEG: result = alu40(req_i.op, op_a, op_b);
			DAU_OP_ALU_NOT: result = alu40(req_i.op, op_a, op_b);
			DAU_OP_ALU_MOV: result = alu40(req_i.op, op_a, op_b);
			// counts past 39 are clamped inside the shift functions, so no wrap of the count
			DAU_OP_SHL: result = sll40(op_a, req_i.shamt);
			DAU_OP_SHR_ARITH: result = sra40(op_a, req_i.shamt);
			DAU_OP_SHR_LOGIC: result = srl40(op_a, req_i.shamt);
			DAU_OP_LOAD: result = req_i.load_data;
			// nop and the unused code retire nothing
			default: writes = 1'b0;
		endcase
		// retire in the same edge: full throughput, no stall
		// the answer carries the full result, even when only some parts are written
		next_state.rsp.valid = req_i.valid && writes;
		next_state.rsp.dst = req_i.dst;
		next_state.rsp.result = result;
		if (req_i.valid && writes) begin
			next_state.general_regs[req_i.dst] = merge_parts(state.general_regs[req_i.dst], result,
				req_i.dst_parts);
		end
		// store path reads the file with this clock's write merged in; a same-cycle write shows in the store word at the same edge
		next_state.store_data = next_state.general_regs[store_rd_i.idx];
	end

	// single state register for the whole unit
	// the async reset clears the file too, so no read after reset sees an unknown
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// outputs are fields of the state register
	assign store_data_o = state.store_data;
	assign rsp_o = state.rsp;

endmodule

// ---- verif/dau_unit_monitor.sv ----
/* checker of the arithmetic unit, watching only its ports.
   assumes one clock domain and the store port read one edge after its index. */
`timescale 1ns/1ps
`include "dau_defines.svh"
module dau_unit_monitor (
	// clock and reset
	input wire logic                  clk_i,
	input wire logic                  arst_n_i,
	// watched ports
	input wire dau_pkg::dau_req_s     req_i,
	input wire dau_pkg::dau_rd_s      store_rd_i,
	input wire logic [`DAU_ACC_W-1:0] store_data_o,
	input wire dau_pkg::dau_rsp_s     rsp_o
);
	import dau_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	logic [2:0]         idx_q;
	logic signed [39:0] sd;
	logic [39:0]        msk;
	logic               tk;
	logic               hit;
	logic               ld;
	// store data of the last index equals what a request reads now, so no shadow is kept
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			idx_q <= '0;
		end else begin
			idx_q <= store_rd_i.idx;
		end
	end
	// request decode
	assign sd = store_data_o;
	assign tk = req_i.valid && req_i.op != DAU_OP_NOP;
	assign hit = tk && req_i.src_a == idx_q;
	assign ld = tk && req_i.op == DAU_OP_LOAD && store_rd_i.idx == req_i.dst;
	assign msk = {{8{req_i.dst_parts[2]}}, {16{req_i.dst_parts[1]}}, {16{req_i.dst_parts[0]}}};
	property p_take; tk |=> rsp_o.valid && rsp_o.dst == $past(req_i.dst); endproperty
	a_take: assert property (p_take) else $error("answer missing");
	property p_refuse; !tk |=> !rsp_o.valid; endproperty
	a_refuse: assert property (p_refuse) else $error("answer without request");
	property p_load; tk && req_i.op == DAU_OP_LOAD |=> rsp_o.result == $past(req_i.load_data); endproperty
	a_load: assert property (p_load) else $error("load result wrong");
	property p_part; ld |=> ((store_data_o ^ $past(req_i.load_data)) & $past(msk)) == '0; endproperty
	a_part: assert property (p_part) else $error("part write wrong");
	property p_mov; hit && req_i.op == DAU_OP_ALU_MOV |=> rsp_o.result == $past(store_data_o); endproperty
	a_mov: assert property (p_mov) else $error("move result wrong");
	property p_shl; hit && req_i.op == DAU_OP_SHL |=> rsp_o.result == $past(store_data_o) << $past(req_i.shamt); endproperty
	a_shl: assert property (p_shl) else $error("left shift wrong");
	property p_shr; hit && req_i.op == DAU_OP_SHR_LOGIC |=> rsp_o.result == $past(store_data_o) >> $past(req_i.shamt); endproperty
	a_shr: assert property (p_shr) else $error("logical shift wrong");
	property p_sha; hit && req_i.op == DAU_OP_SHR_ARITH |=> rsp_o.result == $unsigned($past(sd) >>> $past(req_i.shamt)); endproperty
	a_sha: assert property (p_sha) else $error("arithmetic shift wrong");
endmodule
bind dau_unit dau_unit_monitor mon (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req_i), .store_rd_i(store_rd_i),
	.store_data_o(store_data_o), .rsp_o(rsp_o));

// ---- verif/dau_pc_model.sv ----
/* program control model: issues one decoded request and one store index per clock.
   assumes requests change only at the falling edge. */
`timescale 1ns/1ps
module dau_pc_model (
	// clock
	input  wire logic        clk_i,
	// toward the unit
	output dau_pkg::dau_req_s req_o,
	output dau_pkg::dau_rd_s  rd_o
);
	import dau_pkg::*;
	// idle until the first request
	initial begin
		req_o = '0;
		rd_o = '0;
	end
	// a new request every clock, no gaps between them
	task send(input dau_req_s r, input dau_rd_s s);
		@(negedge clk_i);
		req_o = r;
		rd_o = s;
	endtask
endmodule

// ---- verif/dau_unit_tb.sv ----
/* self-checking bench of the arithmetic unit with a shadow register file.
   assumes the program control model and the bound checker. */
`timescale 1ns/1ps
`include "dau_defines.svh"
module dau_unit_tb;
	import dau_pkg::*;
	logic        clk_i = 1'b0;
	logic        arst_n_i = 1'b0;
	dau_req_s    req;
	dau_rd_s     rd;
	dau_rsp_s    rsp;
	logic [39:0] sdata;
	logic [39:0] rg [8];
	logic [42:0] qr [$];
	logic [42:0] qs [$];
	int          n_errors = 0;
	int          n_checks = 0;
	int          cyc = 0;
	// 250 MHz system clock
	always #2 clk_i = ~clk_i;
	dau_pc_model pc (.clk_i(clk_i), .req_o(req), .rd_o(rd));
	dau_unit dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req), .store_rd_i(rd), .store_data_o(sdata), .rsp_o(rsp));
	task close_out;
		if (n_errors == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task check(input logic [42:0] seen, input logic [42:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// random request; notes come from the shadow before the request is driven
	task step(input logic force_ld);
		dau_req_s           r;
		dau_rd_s            s;
		logic [95:0]        w;
		logic [39:0]        a, b, c, d, e, m;
		logic signed [15:0] x, y;
		logic               tk;
		w = {$urandom, $urandom, $urandom};
		r = w[$bits(dau_req_s)-1:0];
		r.op = dau_op_e'(4'($urandom_range(0, 14)));
		r.valid = $urandom_range(0, 7) != 0;
		if (force_ld) r.op = DAU_OP_LOAD;
		s.idx = 3'($urandom);
		a = rg[r.src_a];
		b = rg[r.src_b];
		d = rg[r.dst];
		x = r.mul_a_high ? a[31:16] : a[15:0];
		y = r.mul_b_high ? b[31:16] : b[15:0];
		e = x * y;
		c = r.pre == DAU_PRE_R1 ? $unsigned($signed(d) >>> 1) : r.pre == DAU_PRE_R16 ? $unsigned($signed(d) >>> 16) : d;
		case (r.op)
			DAU_OP_MAC_ADD: e = c + e;
			DAU_OP_MAC_SUB: e = c - e;
			DAU_OP_ALU_ADD: e = a + b;
			DAU_OP_ALU_SUB: e = a - b;
			DAU_OP_ALU_AND: e = a & b;
			DAU_OP_ALU_OR: e = a | b;
			DAU_OP_ALU_XOR: e = a ^ b;
			DAU_OP_ALU_NEG: e = 40'h00_0000_0000 - a;
			DAU_OP_ALU_NOT: e = ~a;
			DAU_OP_ALU_MOV: e = a;
			DAU_OP_SHL: e = a << r.shamt;
			DAU_OP_SHR_ARITH: e = $unsigned($signed(a) >>> r.shamt);
			DAU_OP_SHR_LOGIC: e = a >> r.shamt;
			DAU_OP_LOAD: e = r.load_data;
			default: e = '0;
		endcase
		m = {{8{r.dst_parts[2]}}, {16{r.dst_parts[1]}}, {16{r.dst_parts[0]}}};
		tk = r.valid && r.op != DAU_OP_NOP;
		if (tk) rg[r.dst] = (rg[r.dst] & ~m) | (e & m);
		// notes go in once the request is on the pins, so the watcher never
		// takes a note at the edge before its request is sampled
		pc.send(r, s);
		if (tk) qr.push_back({r.dst, e});
		qs.push_back({tk, 2'h0, rg[s.idx]});
	endtask
	// outputs are looked at once the edge has settled; cycle ceiling cuts a hang
	always @(posedge clk_i) begin
		#1;
		if (rsp.valid === 1'b1) check({rsp.dst, rsp.result}, qr.pop_front());
		if (qs.size() > 0) check({rsp.valid, 2'h0, sdata}, qs.pop_front());
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			close_out();
		end
	end
	// reset, then back-to-back random traffic, loads first to seed the registers
	initial begin
		foreach (rg[i]) rg[i] = '0;
		void'($urandom(32'h18d3_7560));
		repeat (20) @(posedge clk_i);
		@(negedge clk_i);
		arst_n_i = 1'b1;
		for (int i = 0; i < 1500; i++) step(i < 16);
		pc.send('0, '0);
		repeat (3) @(posedge clk_i);
		check(43'(qr.size()), 43'h0);
		// second reset in mid-run: the file, the answer and the store word all clear
		@(negedge clk_i);
		arst_n_i = 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
		check({rsp.dst, rsp.result}, 43'h0);
		check({2'h0, rsp.valid, sdata}, 43'h0);
		foreach (rg[i]) rg[i] = '0;
		@(negedge clk_i);
		arst_n_i = 1'b1;
		for (int i = 0; i < 1500; i++) step(i < 16);
		pc.send('0, '0);
		repeat (3) @(posedge clk_i);
		check(43'(qr.size()), 43'h0);
		close_out();
	end
endmodule
